// *** core/reset_precedence_consts.vh ***
// register offsets, field positions, reset values and timing counts
// for the reset precedence and boot vector block.
// assumes inclusion by its bare name from core/.
`ifndef RESET_PRECEDENCE_CONSTS_VH
`define RESET_PRECEDENCE_CONSTS_VH

// ==========================================================
// apb register offsets (byte addresses)
`define OFS_SWITCH_CONTROL   12'h000
`define OFS_BOOT_VECTOR      12'h004
`define OFS_PORT_CLOCKING    12'h008
`define OFS_PORT_CONTROL     12'h00C
`define OFS_PARTITION_CTRL   12'h010
`define OFS_BRIDGE_CONTROL   12'h014
`define OFS_RESET_STATUS     12'h018
`define OFS_STICKY_SCRATCH   12'h01C
`define OFS_DEV_STICKY       12'h020
`define OFS_UNLOCK_FIELD     12'h024

// ==========================================================
// switch control register fields
`define CTRL_HALT_BIT        0
`define CTRL_UNLOCK_BIT      1

// ==========================================================
// boot vector status layout
`define BV_FREQ_BIT          0
`define BV_CLKMODE_LSB       1
`define BV_MERGE_LSB         4
`define BV_HALT_BIT          10
`define BV_SMBADDR_LSB       11
`define BV_MODE_LSB          13

// ==========================================================
// reset cause codes, priority order (1 highest, 0 = none)
`define RC_NONE              4'h0
`define RC_GLOBAL            4'h1
`define RC_MODE_CHANGE       4'h2
`define RC_PART_PIN          4'h3
`define RC_PART_CTRL         4'h4
`define RC_HOT_TS1           4'h5
`define RC_DL_DOWN           4'h6
`define RC_UP_SBR            4'h7
`define RC_DN_SBR            4'h8

// ==========================================================
// reset type codes
`define RT_NONE              3'h0
`define RT_SWITCH_FUND       3'h1
`define RT_PORT_MODE         3'h2
`define RT_PART_FUND         3'h3
`define RT_PART_HOT          3'h4
`define RT_UP_SBR            3'h5
`define RT_DN_SBR            3'h6

// ==========================================================
// reset values
`define RST_STICKY           32'h0000_0000
`define RST_DEV_STICKY       32'h0000_0000
`define RST_UNLOCK_FIELD     32'h0000_0000
`define RST_PART_CTRL        32'h0000_0000

// ==========================================================
// timing: unlock hold after global release, in ns and cycles
`define UNLOCK_HOLD_NS       40
`define CLK_PERIOD_NS        4
`define UNLOCK_HOLD_CYC      ((`UNLOCK_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** core/reset_precedence_boot_vector.v ***
// reset arbitration, reset scoping, sticky storage classes and
// boot configuration vector capture with halt control.
// assumes pins are asynchronous to pclk; link events and register
// bits from the switch core are synchronous to pclk.
//
// The APB interface to the registers and the register offsets were decided locally.
`include "reset_precedence_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module reset_precedence_boot_vector #(
    parameter NUM_PORTS = 16
) (
    // clock and reset
    input  wire                 pclk,
    input  wire                 presetn,
    // apb slave
    input  wire                 psel,
    input  wire                 penable,
    input  wire                 pwrite,
    input  wire [11:0]          paddr,
    input  wire [31:0]          pwdata,
    output reg  [31:0]          prdata,
    output wire                 pready,
    output reg                  pslverr,
    // reset pins, asynchronous
    input  wire                 global_reset_pin_n,
    input  wire                 partition_reset_pin_n,
    // boot configuration pins, asynchronous
    input  wire                 global_clock_freq_select,
    input  wire [2:0]           port_clock_mode_pins,
    input  wire                 merge_ports_0_1,
    input  wire                 merge_ports_2_3,
    input  wire                 merge_ports_4_5,
    input  wire                 merge_ports_6_7,
    input  wire                 merge_ports_8_9,
    input  wire                 merge_ports_12_13,
    input  wire                 reset_halt,
    input  wire [1:0]           slave_smbus_address_pins,
    input  wire [3:0]           switch_operating_mode_pins,
    // link events from the upstream port and per-port mode changes, synchronous
    input  wire                 hot_reset_ts1,
    input  wire                 dl_down,
    input  wire [NUM_PORTS-1:0] port_mode_changed,
    // reset outputs
    output reg  [2:0]           device_reset_type,
    output reg  [3:0]           device_reset_cause,
    output reg                  device_reset,
    output reg                  partition_reset,
    output reg  [NUM_PORTS-1:0] port_reset,
    output reg                  quasi_reset,
    output reg                  smbus_active,
    // sampled configuration
    output reg                  refclk_freq_sel,
    output reg  [2:0]           port_clock_mode,
    output reg  [5:0]           merge_enables,
    output reg  [1:0]           slave_smbus_address,
    output reg  [3:0]           switch_operating_mode
);

// ==========================================================
// functions
function [2:0] cause_type;
    input [3:0] c;
    begin
        case (c)
            `RC_GLOBAL:      cause_type = `RT_SWITCH_FUND;
            `RC_MODE_CHANGE: cause_type = `RT_PORT_MODE;
            `RC_PART_PIN:    cause_type = `RT_PART_FUND;
            `RC_PART_CTRL:   cause_type = `RT_PART_FUND;
            `RC_HOT_TS1:     cause_type = `RT_PART_HOT;
            `RC_DL_DOWN:     cause_type = `RT_PART_HOT;
            `RC_UP_SBR:      cause_type = `RT_UP_SBR;
            `RC_DN_SBR:      cause_type = `RT_DN_SBR;
            default:         cause_type = `RT_NONE;
        endcase
    end
endfunction

// ==========================================================
// pin synchronisers; the first stage feeds only the second
reg  [18:0] pin_meta_q;
reg  [18:0] pin_sync_q;
wire [18:0] pin_raw = {global_reset_pin_n, partition_reset_pin_n,
                       switch_operating_mode_pins,
                       slave_smbus_address_pins, reset_halt,
                       merge_ports_12_13, merge_ports_8_9,
                       merge_ports_6_7, merge_ports_4_5,
                       merge_ports_2_3, merge_ports_0_1,
                       port_clock_mode_pins, global_clock_freq_select};

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pin_meta_q <= 19'h00000;
        pin_sync_q <= 19'h00000;
    end else begin
        pin_meta_q <= pin_raw;
        pin_sync_q <= pin_meta_q;
    end
end

// synced pins; reset pins read as asserted while flops are cleared
wire        glob_n   = pin_sync_q[18];
wire        part_n   = pin_sync_q[17];
wire [16:0] bv_pins  = pin_sync_q[16:0];

// ==========================================================
// registers
reg         halt_q;
reg         unlock_q;
reg         clk_override_q;
reg  [2:0]  clk_reg_q;
reg  [NUM_PORTS-1:0] mode_action_q;
reg         part_ctrl_fund_q;
reg         up_sbr_q;
reg  [NUM_PORTS-1:0] dn_sbr_q;
reg  [31:0] sticky_q;
reg  [31:0] dev_sticky_q;
reg  [31:0] unlock_field_q;
reg  [16:0] bv_status_q;
reg         glob_seen_q;
reg  [7:0]  unlock_cnt_q;
reg         boot_done_q;

localparam [7:0] UNLOCK_CYC = `UNLOCK_HOLD_CYC;

// ==========================================================
// priority encoder, evaluated every cycle
wire [NUM_PORTS-1:0] mode_rst = port_mode_changed & mode_action_q;
reg  [3:0] cause_d;

always @* begin
    if (!glob_n)                cause_d = `RC_GLOBAL;
    else if (|mode_rst)         cause_d = `RC_MODE_CHANGE;
    else if (!part_n)           cause_d = `RC_PART_PIN;
    else if (part_ctrl_fund_q)  cause_d = `RC_PART_CTRL;
    else if (hot_reset_ts1)     cause_d = `RC_HOT_TS1;
    else if (dl_down)           cause_d = `RC_DL_DOWN;
    else if (up_sbr_q)          cause_d = `RC_UP_SBR;
    else if (|dn_sbr_q)         cause_d = `RC_DN_SBR;
    else                        cause_d = `RC_NONE;
end

wire [2:0] type_d = cause_type(cause_d);
// fundamental classes decide which storage is reinitialised
wire sw_fund   = (device_reset_type == `RT_SWITCH_FUND);
wire part_fund = (device_reset_type == `RT_PART_FUND);

// the encoder output is registered: a change lands one cycle later
// and passes straight to the next cause without a gap
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        device_reset_cause <= `RC_GLOBAL;
        device_reset_type  <= `RT_SWITCH_FUND;
        device_reset       <= 1'b1;
        partition_reset    <= 1'b1;
        port_reset         <= {NUM_PORTS{1'b1}};
    end else begin
        device_reset_cause <= cause_d;
        device_reset_type  <= type_d;
        device_reset       <= (type_d == `RT_SWITCH_FUND);
        partition_reset    <= (type_d == `RT_SWITCH_FUND) ||
                              (type_d == `RT_PART_FUND) ||
                              (type_d == `RT_PART_HOT) ||
                              (type_d == `RT_UP_SBR);
        case (type_d)
            `RT_SWITCH_FUND, `RT_PART_FUND, `RT_PART_HOT, `RT_UP_SBR:
                port_reset <= {NUM_PORTS{1'b1}};
            `RT_PORT_MODE:
                port_reset <= mode_rst;
            `RT_DN_SBR:
                port_reset <= dn_sbr_q;
            default:
                port_reset <= {NUM_PORTS{1'b0}};
        endcase
    end
end

// ==========================================================
// boot vector capture at release of the global reset pin
wire glob_release = glob_seen_q && glob_n;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        glob_seen_q  <= 1'b0;
        bv_status_q  <= 17'h00000;
        unlock_cnt_q <= 8'h00;
        boot_done_q  <= 1'b0;
    end else begin
        glob_seen_q <= !glob_n;
        if (glob_release) begin
            // pins ignored at every other time
            bv_status_q  <= bv_pins;
            unlock_cnt_q <= UNLOCK_CYC;
            boot_done_q  <= 1'b0;
        end else if (!glob_n) begin
            boot_done_q  <= 1'b0;
        end else if (unlock_cnt_q != 8'h00) begin
            unlock_cnt_q <= unlock_cnt_q - 8'h01;
        end else begin
            boot_done_q  <= 1'b1;
        end
    end
end

// decode sampled fields; the non-overridable ones come only from here
always @* begin
    refclk_freq_sel       = bv_status_q[`BV_FREQ_BIT];
    merge_enables         = bv_status_q[`BV_MERGE_LSB +: 6];
    slave_smbus_address   = bv_status_q[`BV_SMBADDR_LSB +: 2];
    switch_operating_mode = bv_status_q[`BV_MODE_LSB +: 4];
    port_clock_mode       = clk_override_q ? clk_reg_q :
                            bv_status_q[`BV_CLKMODE_LSB +: 3];
    // halted reset: ports quasi-reset while smbus stays up
    quasi_reset           = halt_q && boot_done_q;
    smbus_active          = glob_n;
end

// ==========================================================
// apb slave; zero wait states
wire wr_en = psel && penable && pwrite;
wire rd_en = psel && !pwrite;
assign pready = 1'b1;

function addr_ok;
    input [11:0] a;
    begin
        addr_ok = (a <= `OFS_UNLOCK_FIELD) && (a[1:0] == 2'b00);
    end
endfunction

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        halt_q           <= 1'b0;
        unlock_q         <= 1'b0;
        clk_override_q   <= 1'b0;
        clk_reg_q        <= 3'h0;
        mode_action_q    <= {NUM_PORTS{1'b0}};
        part_ctrl_fund_q <= 1'b0;
        up_sbr_q         <= 1'b0;
        dn_sbr_q         <= {NUM_PORTS{1'b0}};
    end else if (sw_fund) begin
        // ordinary registers take defaults under switch reset, except unlock_q, which is set;
        // the halt strap lands here, as release is still in this state
        halt_q           <= glob_release && bv_pins[`BV_HALT_BIT];
        unlock_q         <= 1'b1;
        clk_override_q   <= 1'b0;
        clk_reg_q        <= 3'h0;
        mode_action_q    <= {NUM_PORTS{1'b0}};
        part_ctrl_fund_q <= 1'b0;
        up_sbr_q         <= 1'b0;
        dn_sbr_q         <= {NUM_PORTS{1'b0}};
    end else begin
        if (glob_release) begin
            halt_q   <= bv_pins[`BV_HALT_BIT];
            unlock_q <= 1'b1;
        end else if (boot_done_q && !halt_q) begin
            unlock_q <= 1'b0;
        end
        if (wr_en) begin
            case (paddr)
                `OFS_SWITCH_CONTROL: begin
                    halt_q   <= pwdata[`CTRL_HALT_BIT];
                    unlock_q <= pwdata[`CTRL_UNLOCK_BIT];
                end
                `OFS_PORT_CLOCKING: begin
                    clk_reg_q      <= pwdata[2:0];
                    clk_override_q <= 1'b1;
                end
                `OFS_PORT_CONTROL:
                    mode_action_q <= pwdata[NUM_PORTS-1:0];
                `OFS_PARTITION_CTRL:
                    part_ctrl_fund_q <= pwdata[0];
                `OFS_BRIDGE_CONTROL: begin
                    up_sbr_q <= pwdata[0];
                    dn_sbr_q <= pwdata[NUM_PORTS:1];
                end
                default: ;
            endcase
        end
    end
end

// storage classes: sticky, device sticky, write-when-unlocked
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sticky_q       <= `RST_STICKY;
        dev_sticky_q   <= `RST_DEV_STICKY;
        unlock_field_q <= `RST_UNLOCK_FIELD;
    end else begin
        if (sw_fund || part_fund)
            sticky_q <= `RST_STICKY;
        else if (wr_en && paddr == `OFS_STICKY_SCRATCH)
            sticky_q <= pwdata;
        if (sw_fund)
            dev_sticky_q <= `RST_DEV_STICKY;
        else if (wr_en && paddr == `OFS_DEV_STICKY)
            dev_sticky_q <= pwdata;
        if (sw_fund)
            unlock_field_q <= `RST_UNLOCK_FIELD;
        else if (wr_en && unlock_q && paddr == `OFS_UNLOCK_FIELD)
            unlock_field_q <= pwdata;
    end
end

// read data and error, registered in the setup cycle
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b0;
    end else if (psel && !penable) begin
        pslverr <= !addr_ok(paddr);
        prdata  <= 32'h0000_0000;
        if (rd_en) begin
            case (paddr)
                `OFS_SWITCH_CONTROL:
                    prdata <= {30'h0, unlock_q, halt_q};
                `OFS_BOOT_VECTOR:
                    prdata <= {15'h0, bv_status_q};
                `OFS_PORT_CLOCKING:
                    prdata <= {29'h0, port_clock_mode};
                `OFS_PORT_CONTROL:
                    prdata <= {{(32-NUM_PORTS){1'b0}}, mode_action_q};
                `OFS_PARTITION_CTRL:
                    prdata <= {31'h0, part_ctrl_fund_q};
                `OFS_BRIDGE_CONTROL:
                    prdata <= {{(31-NUM_PORTS){1'b0}}, dn_sbr_q, up_sbr_q};
                `OFS_RESET_STATUS:
                    prdata <= {24'h0, 1'b0, device_reset_type,
                               device_reset_cause};
                `OFS_STICKY_SCRATCH:
                    prdata <= sticky_q;
                `OFS_DEV_STICKY:
                    prdata <= dev_sticky_q;
                `OFS_UNLOCK_FIELD:
                    prdata <= unlock_field_q;
                default:
                    prdata <= 32'h0000_0000;
            endcase
        end
    end
end

endmodule
`default_nettype wire

// *** test/reset_precedence_chk.sv ***
// concurrent checks on the reset precedence and boot vector block.
// assumes one clock domain, bound to the top module by name.
`timescale 1ns/1ps
`default_nettype none
module reset_precedence_chk #(
    parameter NUM_PORTS = 16
) (
    // clock and reset
    input wire logic                 pclk,
    input wire logic                 presetn,
    // pins and events
    input wire logic                 global_reset_pin_n,
    input wire logic                 partition_reset_pin_n,
    input wire logic                 hot_reset_ts1,
    input wire logic                 dl_down,
    input wire logic [NUM_PORTS-1:0] port_mode_changed,
    // outputs watched
    input wire logic [2:0]           device_reset_type,
    input wire logic [3:0]           device_reset_cause,
    input wire logic                 device_reset,
    input wire logic                 partition_reset,
    input wire logic                 quasi_reset,
    input wire logic                 smbus_active,
    input wire logic                 refclk_freq_sel,
    input wire logic [5:0]           merge_enables,
    input wire logic [3:0]           switch_operating_mode
);
    // ==========================================================
    // properties
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // pins need three quiet samples to clear the synchroniser
    logic quiet;
    assign quiet = global_reset_pin_n && partition_reset_pin_n
                   && port_mode_changed == '0;

    global_wins_a: assert property (!global_reset_pin_n [*3] |=>
        device_reset_type == 3'h1 && device_reset_cause == 4'h1)
        else $error("global pin did not win");
    scope_dev_a: assert property (device_reset ==
        (device_reset_type == 3'h1)) else $error("device scope wrong");
    scope_part_a: assert property (partition_reset ==
        (device_reset_type inside {3'h1, 3'h3, 3'h4, 3'h5}))
        else $error("partition scope wrong");
    ts1_next_a: assert property (quiet [*3] ##0 hot_reset_ts1 &&
        (device_reset_cause == 4'h0 || device_reset_cause > 4'h4) |=>
        device_reset_cause == 4'h5 && device_reset_type == 3'h4)
        else $error("hot reset not taken next cycle");
    fall_thru_a: assert property (quiet [*3] ##0 $fell(hot_reset_ts1)
        && dl_down && device_reset_cause == 4'h5 |-> partition_reset
        ##1 (device_reset_cause == 4'h6 && partition_reset))
        else $error("no seamless fall through");
    quasi_smb_a: assert property (quasi_reset |->
        smbus_active && !device_reset) else $error("halt state wrong");
    cfg_hold_a: assert property (device_reset_type != 3'h1 &&
        $past(device_reset_type) != 3'h1 &&
        $past(device_reset_type, 2) != 3'h1 |-> $stable({refclk_freq_sel,
        merge_enables, switch_operating_mode}))
        else $error("boot config moved outside reset");
    mode_port_a: assert property (device_reset_cause == 4'h2 |->
        device_reset_type == 3'h2 && !partition_reset)
        else $error("mode change reset scope wrong");
    part_fund_a: assert property (device_reset_cause inside
        {4'h3, 4'h4} |-> device_reset_type == 3'h3)
        else $error("partition fundamental type wrong");

    cover property (quiet ##0 $fell(hot_reset_ts1) && dl_down);
    cover property ($rose(quasi_reset));
    cover property (device_reset_cause == 4'h3);
    cover property (device_reset_cause == 4'h8);
endmodule
`default_nettype wire

// *** test/board_reset_model.sv ***
// board reset logic: drives the reset pins and the boot strap pins.
// assumes the bench changes its requests just after pclk edges.
`timescale 1ns/1ps
`default_nettype none
module board_reset_model (
    // bench requests
    input  wire logic        glob_req,
    input  wire logic        part_req,
    input  wire logic [16:0] boot,
    // reset pins
    output wire logic        global_reset_pin_n,
    output wire logic        partition_reset_pin_n,
    // boot strap pins
    output wire logic        global_clock_freq_select,
    output wire logic [2:0]  port_clock_mode_pins,
    output wire logic        merge_ports_0_1,
    output wire logic        merge_ports_2_3,
    output wire logic        merge_ports_4_5,
    output wire logic        merge_ports_6_7,
    output wire logic        merge_ports_8_9,
    output wire logic        merge_ports_12_13,
    output wire logic        reset_halt,
    output wire logic [1:0]  slave_smbus_address_pins,
    output wire logic [3:0]  switch_operating_mode_pins
);
    // ==========================================================
    // pins follow the requests; straps are held by the bench
    // across the global release so the capture sees one value
    assign global_reset_pin_n = !glob_req;
    assign partition_reset_pin_n = !part_req;
    assign {switch_operating_mode_pins, slave_smbus_address_pins,
            reset_halt, merge_ports_12_13, merge_ports_8_9,
            merge_ports_6_7, merge_ports_4_5, merge_ports_2_3,
            merge_ports_0_1, port_clock_mode_pins,
            global_clock_freq_select} = boot;
endmodule
`default_nettype wire

// *** test/reset_precedence_boot_vector_tb.sv ***
// self-checking bench for the reset precedence and boot vector block.
// assumes the board model drives pins and the bench acts as apb master.
`timescale 1ns/1ps
`default_nettype none
module reset_precedence_boot_vector_tb;
    // ==========================================================
    // stimulus and observed signals
    localparam logic [16:0] BOOT_A = {4'hA, 2'h2, 1'h1, 6'h2D, 3'h5, 1'h1};
    localparam logic [16:0] BOOT_B = {4'h3, 2'h1, 1'h0, 6'h12, 3'h2, 1'h0};
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic        hot_reset_ts1 = 0, dl_down = 0, glob_req = 1, part_req = 0;
    logic        er;
    logic [15:0] port_mode_changed = 16'h0000;
    logic [16:0] boot = BOOT_A;
    wire  [31:0] prdata;
    wire  [15:0] port_reset;
    wire  [5:0]  merge_enables;
    wire  [3:0]  device_reset_cause, switch_operating_mode;
    wire  [3:0]  switch_operating_mode_pins;
    wire  [2:0]  device_reset_type, port_clock_mode, port_clock_mode_pins;
    wire  [1:0]  slave_smbus_address, slave_smbus_address_pins;
    wire pready, pslverr, device_reset, partition_reset, quasi_reset;
    wire smbus_active, refclk_freq_sel, global_reset_pin_n;
    wire partition_reset_pin_n, global_clock_freq_select, reset_halt;
    wire merge_ports_0_1, merge_ports_2_3, merge_ports_4_5;
    wire merge_ports_6_7, merge_ports_8_9, merge_ports_12_13;
    int fails = 0, n_compared = 0, cyc = 0;

    board_reset_model board_reset_model_i (.glob_req, .part_req, .boot,
        .global_reset_pin_n, .partition_reset_pin_n,
        .global_clock_freq_select, .port_clock_mode_pins, .merge_ports_0_1,
        .merge_ports_2_3, .merge_ports_4_5, .merge_ports_6_7,
        .merge_ports_8_9, .merge_ports_12_13, .reset_halt,
        .slave_smbus_address_pins, .switch_operating_mode_pins);
    reset_precedence_boot_vector reset_precedence_boot_vector_i (.pclk,
        .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .global_reset_pin_n, .partition_reset_pin_n,
        .global_clock_freq_select, .port_clock_mode_pins, .merge_ports_0_1,
        .merge_ports_2_3, .merge_ports_4_5, .merge_ports_6_7,
        .merge_ports_8_9, .merge_ports_12_13, .reset_halt,
        .slave_smbus_address_pins, .switch_operating_mode_pins,
        .hot_reset_ts1, .dl_down, .port_mode_changed, .device_reset_type,
        .device_reset_cause, .device_reset, .partition_reset, .port_reset,
        .quasi_reset, .smbus_active, .refclk_freq_sel, .port_clock_mode,
        .merge_enables, .slave_smbus_address, .switch_operating_mode);

    // ==========================================================
    // clock, timeout and shared tasks
    always #2 pclk = ~pclk;
    // whole run is under two hundred cycles; far ceiling catches hangs
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            results();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // zero-wait slave still waits on pready like any master
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wait_cause(input logic [3:0] c);
        for (int i = 0; i < 40 && device_reset_cause !== c; i++)
            @(negedge pclk);
        chk(device_reset_cause, c);
    endtask
    task automatic wait_free;
        for (int i = 0; i < 40 && device_reset !== 1'b0; i++)
            @(negedge pclk);
    endtask

    // ==========================================================
    // scenarios
    task automatic boot_halt;
        @(posedge pclk) glob_req <= 0;
        wait_free();
        @(posedge pclk) boot <= BOOT_B; // straps move after capture
        for (int i = 0; i < 40 && quasi_reset !== 1'b1; i++) @(negedge pclk);
        chk(quasi_reset, 1'b1);
        chk({refclk_freq_sel, port_clock_mode}, {1'b1, 3'h5});
        chk(merge_enables, 6'h2D);
        chk({slave_smbus_address, switch_operating_mode}, 6'h2A);
        apb(0, 12'h004, 0); chk(rd, {15'h0, BOOT_A});
        apb(0, 12'h000, 0); chk(rd, 32'h3);
        apb(1, 12'h024, 32'h12345678);
        apb(1, 12'h000, 32'h2);
        @(negedge pclk) chk(quasi_reset, 1'b0);
        apb(0, 12'h000, 0); chk(rd, 32'h0);
        $display("boot_halt done");
    endtask
    task automatic precedence;
        @(posedge pclk) begin hot_reset_ts1 <= 1; dl_down <= 1; end
        wait_cause(4'h5);
        chk({device_reset_type, port_reset}, {3'h4, 16'hFFFF});
        @(posedge pclk) hot_reset_ts1 <= 0;
        @(posedge pclk) @(negedge pclk) chk(device_reset_cause, 4'h6);
        chk(partition_reset, 1'b1);
        apb(1, 12'h00C, 32'h8);
        @(posedge pclk) port_mode_changed <= 16'h0008;
        wait_cause(4'h2);
        chk(port_reset, 16'h0008);
        @(posedge pclk) part_req <= 1;
        repeat (5) @(negedge pclk);
        chk(device_reset_cause, 4'h2);
        @(posedge pclk) port_mode_changed <= 16'h0000;
        wait_cause(4'h3);
        @(posedge pclk) part_req <= 0;
        wait_cause(4'h6);
        @(posedge pclk) dl_down <= 0;
        wait_cause(4'h0);
        $display("precedence done");
    endtask
    task automatic storage;
        apb(1, 12'h01C, 32'hA5A5A5A5);
        apb(1, 12'h020, 32'h5A5A5A5A);
        apb(1, 12'h024, 32'h0BAD0BAD);
        apb(1, 12'h010, 32'h1);
        wait_cause(4'h4);
        chk(device_reset_type, 3'h3);
        apb(1, 12'h010, 32'h0);
        apb(0, 12'h01C, 0); chk(rd, 32'h0);
        apb(0, 12'h020, 0); chk(rd, 32'h5A5A5A5A);
        apb(0, 12'h024, 0); chk(rd, 32'h12345678);
        apb(1, 12'h01C, 32'hA5A5A5A5);
        apb(1, 12'h014, 32'h1);
        wait_cause(4'h7);
        apb(1, 12'h014, 32'h4);
        wait_cause(4'h8);
        chk(port_reset, 16'h0002);
        apb(0, 12'h018, 0); chk(rd, 32'h68);
        apb(1, 12'h014, 32'h0);
        apb(0, 12'h01C, 0); chk(rd, 32'hA5A5A5A5);
        apb(1, 12'h008, 32'h6);
        @(negedge pclk) chk(port_clock_mode, 3'h6);
        apb(0, 12'h028, 0); chk(rd, 32'h0); chk(er, 1'b1);
        $display("storage done");
    endtask
    task automatic global_again;
        @(posedge pclk) begin dl_down <= 1; glob_req <= 1; end
        wait_cause(4'h1);
        @(posedge pclk) glob_req <= 0;
        wait_free();
        wait_cause(4'h6);
        chk({merge_enables, switch_operating_mode}, {6'h12, 4'h3});
        chk(port_clock_mode, 3'h2);
        apb(0, 12'h020, 0); chk(rd, 32'h0);
        apb(0, 12'h024, 0); chk(rd, 32'h0);
        repeat (20) @(negedge pclk);
        chk(quasi_reset, 1'b0);
        @(posedge pclk) dl_down <= 0;
        $display("global_again done");
    endtask
    task results;
        $display("fails=%0d compared=%0d", fails, n_compared);
        if (fails == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        repeat (3) @(posedge pclk);
        boot_halt();
        precedence();
        storage();
        global_again();
        results();
    end
endmodule
bind reset_precedence_boot_vector reset_precedence_chk #(
    .NUM_PORTS(NUM_PORTS)) chk_i (.pclk, .presetn, .global_reset_pin_n,
    .partition_reset_pin_n, .hot_reset_ts1, .dl_down, .port_mode_changed,
    .device_reset_type, .device_reset_cause, .device_reset,
    .partition_reset, .quasi_reset, .smbus_active, .refclk_freq_sel,
    .merge_enables, .switch_operating_mode);
`default_nettype wire
